/* smdb_pkg.sv */
/*
 package of the serial master with buffer engine: register map, field layout, reset values, timing.
 assumes a 32-bit axi4-lite slave in front of the block.
*/
package smdb_pkg;
  // register word indices (printed offsets used as indices, byte address = 4 * index)
  localparam logic [7:0] SMDB_IDX_CTRL = 8'hB1;
  localparam logic [7:0] SMDB_IDX_RATE = 8'hB2;
  localparam logic [7:0] SMDB_IDX_LEN = 8'hB3;
  localparam logic [7:0] SMDB_IDX_OWN = 8'hD6;
  localparam logic [7:0] SMDB_IDX_IRQ_STAT = 8'hE0;
  localparam logic [7:0] SMDB_IDX_IRQ_MASK = 8'hE1;
  localparam logic [7:0] SMDB_IDX_BUF1 = 8'h40;
  localparam logic [7:0] SMDB_IDX_BUF2 = 8'h80;
  // control field positions
  localparam int SMDB_CTRL_PINSEL = 7;
  localparam int SMDB_CTRL_GO = 6;
  localparam int SMDB_CTRL_CPOL = 5;
  localparam int SMDB_CTRL_CPHA = 4;
  localparam int SMDB_CTRL_DIR = 3;
  localparam int SMDB_CTRL_LSBF = 2;
  localparam int SMDB_CTRL_PCLR = 0;
  // ownership field positions
  localparam int SMDB_OWN_B1 = 3;
  localparam int SMDB_OWN_B2 = 2;
  // reset values
  localparam logic [7:0] SMDB_RST_BYTE = 8'h00;
  // buffer size
  localparam int SMDB_BUF_BYTES = 64;
  // timing: fast oscillator 24 MHz emulated from the 200 MHz system clock
  localparam int SMDB_SYS_KHZ = 200000;
  localparam int SMDB_FAST_KHZ = 24000;
  // system cycles per fast-clock tick, rounded down (shortest spacing)
  localparam int SMDB_TICK_CYC = SMDB_SYS_KHZ / SMDB_FAST_KHZ;
  // states
  typedef enum logic [1:0]
  {
    SMDB_IDLE = 2'b00,
    SMDB_LOAD = 2'b01,
    SMDB_SHIFT = 2'b10,
    SMDB_STORE = 2'b11
  } smdb_state_e;
endpackage

/* smdb_buf_if.sv */
/*
 interface between engine and buffer store: one byte port.
 assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface smdb_buf_if;
  logic sel2; // 1 = buffer two
  logic [5:0] addr; // byte index
  logic we; // write strobe
  logic [7:0] wdata; // byte to store
  logic [7:0] rdata; // byte read back
  modport eng (output sel2, output addr, output we, output wdata, input rdata);
  modport mem (input sel2, input addr, input we, input wdata, output rdata);
endinterface

/* smdb_bufmem.sv */
/*
 two 64-byte flip-flop buffers with an engine port and a software port.
 assumes engine and software never write in one cycle; engine wins and the software write to any byte is dropped.
*/
`timescale 1ns/1ps
module smdb_bufmem
  import smdb_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  smdb_buf_if.mem eng,
  input wire logic SW_WE,
  input wire logic SW_SEL2,
  input wire logic [5:0] SW_ADDR,
  input wire logic [7:0] SW_WDATA,
  output logic [7:0] SW_RDATA
);
  // storage, index 0..63 buffer one, 64..127 buffer two
  logic [7:0] mem_ff [2*SMDB_BUF_BYTES];
  logic [6:0] ea;
  logic [6:0] sa;
  assign ea = {eng.sel2, eng.addr};
  assign sa = {SW_SEL2, SW_ADDR};
  assign eng.rdata = mem_ff[ea];
  assign SW_RDATA = mem_ff[sa];
  // write port: engine first, then software
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      for (int i = 0; i < 2*SMDB_BUF_BYTES; i++)
        mem_ff[i] <= SMDB_RST_BYTE;
    end
    else if (eng.we)
      mem_ff[ea] <= eng.wdata;
    else if (SW_WE)
      mem_ff[sa] <= SW_WDATA;
  end
endmodule

/* smdb_engine.sv */
/*
 serial master engine with axi4-lite register file and buffer store.
 assumes axi4-lite master with one read and one write in flight; chip select by gpio outside.
*/
`timescale 1ns/1ps
module smdb_engine
  import smdb_pkg::*;
#(
  parameter int TICK_CYC = SMDB_TICK_CYC
)
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [2:0] GPIO_OUT,
  input wire logic [2:0] GPIO_OE_N,
  output logic [2:0] GPIO_IN,
  output logic SERIAL_CLOCK_OUT,
  output logic SERIAL_DATA_OUT,
  input wire logic SERIAL_DATA_IN,
  output logic [2:0] PIN_OUT,
  output logic [2:0] PIN_OE_N,
  input wire logic [2:0] PIN_IN,
  output logic IRQ
);
  // elaboration check: tick nonzero, and tick * 128 must fit the 14-bit half-period counter
  if (TICK_CYC < 1 || TICK_CYC > 127)
  begin
    $error("tick count out of range");
  end
  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] ctrl_ff; // control, bit 6 is go/busy
  logic [6:0] rate_ff; // bit rate select
  logic [6:0] len_ff; // transfer byte count
  logic [7:0] own_ff; // buffer ownership
  logic stat_ff; // done event, sticky
  logic mask_ff; // done enable
  logic [5:0] ptr_ff; // buffer pointer
  // axi state
  logic aw_ff;
  logic [31:0] awaddr_ff;
  logic w_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  // engine state
  smdb_state_e state_ff;
  logic [6:0] left_ff; // bytes left
  logic [7:0] sh_ff; // shift register
  logic [3:0] edge_ff; // edges done in byte, 0..15
  logic [13:0] div_ff; // half-period cycle counter
  logic sclk_ff; // serial clock
  logic dout_ff; // data out
  logic cpol_q_ff, cpha_q_ff, dir_q_ff, lsbf_q_ff, sel2_q_ff;
  logic [6:0] rate_q_ff;
  logic done_pulse;
  smdb_buf_if bif ();
  // software buffer port
  logic sw_we;
  logic [7:0] sw_rdata;
  //////////////////////////////////////////////////////////////////////////////
  // decode: word index from byte address, valid only when aligned
  function automatic logic [7:0] widx(input logic [31:0] a);
    widx = a[9:2];
  endfunction
  function automatic logic is_buf(input logic [7:0] i);
    is_buf = (i[7:6] == 2'b01) || (i[7:6] == 2'b10);
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // write channel capture
  logic do_write;
  logic [7:0] wi;
  assign S_AXI_AWREADY = !aw_ff && !bvalid_ff;
  assign S_AXI_WREADY = !w_ff && !bvalid_ff;
  assign do_write = aw_ff && w_ff && !bvalid_ff;
  assign wi = widx(awaddr_ff);
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 32'h0000_0000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'b00;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_ff <= 1'b1;
        awaddr_ff <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_ff <= 1'b1;
        wdata_ff <= S_AXI_WDATA;
        wstrb_ff <= S_AXI_WSTRB;
      end
      if (do_write)
      begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        // unmapped address answers slverr
        case (wi)
          SMDB_IDX_CTRL, SMDB_IDX_RATE, SMDB_IDX_LEN, SMDB_IDX_OWN, SMDB_IDX_IRQ_STAT, SMDB_IDX_IRQ_MASK:
            bresp_ff <= 2'b00;
          default:
            bresp_ff <= is_buf(wi) ? 2'b00 : 2'b10;
        endcase
      end
      else if (bvalid_ff && S_AXI_BREADY)
        bvalid_ff <= 1'b0;
    end
  end
  logic wr_lo;
  assign wr_lo = do_write && wstrb_ff[0];
  //////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rate_ff <= 7'h00;
      len_ff <= 7'h00;
      own_ff <= 8'h00;
      mask_ff <= 1'b0;
    end
    else if (wr_lo)
    begin
      if (wi == SMDB_IDX_RATE)
        rate_ff <= wdata_ff[6:0];
      if (wi == SMDB_IDX_LEN)
        len_ff <= wdata_ff[6:0];
      if (wi == SMDB_IDX_OWN)
        own_ff <= wdata_ff[7:0];
      if (wi == SMDB_IDX_IRQ_MASK)
        mask_ff <= wdata_ff[0];
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // control register; go bit set by software, cleared by engine
  logic start;
  assign start = wr_lo && (wi == SMDB_IDX_CTRL) && wdata_ff[SMDB_CTRL_GO] && !ctrl_ff[SMDB_CTRL_GO];
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      ctrl_ff <= 8'h00;
    else
    begin
      if (wr_lo && (wi == SMDB_IDX_CTRL))
      begin
        ctrl_ff[7] <= wdata_ff[7];
        ctrl_ff[5:2] <= wdata_ff[5:2];
      end
      if (start)
        ctrl_ff[SMDB_CTRL_GO] <= 1'b1;
      else if (done_pulse)
        ctrl_ff[SMDB_CTRL_GO] <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // interrupt: done event sticky, write one clears, set wins
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      stat_ff <= 1'b0;
    else if (done_pulse)
      stat_ff <= 1'b1;
    else if (wr_lo && (wi == SMDB_IDX_IRQ_STAT) && wdata_ff[0])
      stat_ff <= 1'b0;
  end
  assign IRQ = stat_ff && mask_ff;
  //////////////////////////////////////////////////////////////////////////////
  // read channel
  logic [7:0] ri;
  assign ri = widx(S_AXI_ARADDR);
  assign S_AXI_ARREADY = !rvalid_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA = rdata_ff;
  assign S_AXI_RRESP = rresp_ff;
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'b00;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= 2'b00;
      case (ri)
        SMDB_IDX_CTRL: rdata_ff <= {24'h00_0000, ctrl_ff[7:2], 2'b00};
        SMDB_IDX_RATE: rdata_ff <= {25'h000_0000, rate_ff};
        SMDB_IDX_LEN: rdata_ff <= {25'h000_0000, len_ff};
        SMDB_IDX_OWN: rdata_ff <= {24'h00_0000, own_ff};
        SMDB_IDX_IRQ_STAT: rdata_ff <= {31'h0000_0000, stat_ff};
        SMDB_IDX_IRQ_MASK: rdata_ff <= {31'h0000_0000, mask_ff};
        default:
        begin
          rdata_ff <= is_buf(ri) ? {24'h00_0000, sw_rdata} : 32'h0000_0000;
          rresp_ff <= is_buf(ri) ? 2'b00 : 2'b10;
        end
      endcase
    end
    else if (rvalid_ff && S_AXI_RREADY)
      rvalid_ff <= 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // buffer store; software reaches bytes through the buffer windows
  assign sw_we = do_write && wstrb_ff[0] && is_buf(wi);
  smdb_bufmem u_mem (
    .CLK(CLK),
    .RSTN(RSTN),
    .eng(bif),
    .SW_WE(sw_we),
    .SW_SEL2(sw_we ? wi[7] : ri[7]),
    .SW_ADDR(sw_we ? wi[5:0] : ri[5:0]),
    .SW_WDATA(wdata_ff[7:0]),
    .SW_RDATA(sw_rdata)
  );
  //////////////////////////////////////////////////////////////////////////////
  // serial engine
  logic [13:0] half_cyc; // cycles per half period = tick * (n+1)
  logic half_done;
  logic samp_edge;
  logic last_edge;
  // widen before adding one, so select 127 does not wrap to a zero period
  assign half_cyc = 14'(TICK_CYC) * ({7'h00, rate_q_ff} + 14'h0001);
  assign half_done = (div_ff == half_cyc - 14'h0001);
  // phase picks sample parity: edge_ff counts done edges
  assign samp_edge = cpha_q_ff ? edge_ff[0] : !edge_ff[0];
  assign last_edge = (edge_ff == 4'd15);
  assign bif.sel2 = sel2_q_ff;
  assign bif.addr = ptr_ff;
  assign bif.wdata = sh_ff;
  // a zero count stores nothing but still finishes
  assign bif.we = (state_ff == SMDB_STORE) && dir_q_ff && (left_ff != 7'h00);
  assign done_pulse = (state_ff == SMDB_STORE) && (left_ff <= 7'h01);
  // out bit from shift register per order
  logic nxt_bit;
  assign nxt_bit = lsbf_q_ff ? sh_ff[0] : sh_ff[7];
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_ff <= SMDB_IDLE;
      left_ff <= 7'h00;
      sh_ff <= 8'h00;
      edge_ff <= 4'h0;
      div_ff <= 14'h0000;
      sclk_ff <= 1'b0;
      dout_ff <= 1'b0;
      cpol_q_ff <= 1'b0;
      cpha_q_ff <= 1'b0;
      dir_q_ff <= 1'b0;
      lsbf_q_ff <= 1'b0;
      sel2_q_ff <= 1'b0;
      rate_q_ff <= 7'h00;
    end
    else
    begin
      case (state_ff)
        SMDB_IDLE:
        begin
          sclk_ff <= ctrl_ff[SMDB_CTRL_CPOL];
          if (start)
          begin
            cpol_q_ff <= wdata_ff[SMDB_CTRL_CPOL];
            cpha_q_ff <= wdata_ff[SMDB_CTRL_CPHA];
            dir_q_ff <= wdata_ff[SMDB_CTRL_DIR];
            lsbf_q_ff <= wdata_ff[SMDB_CTRL_LSBF];
            sel2_q_ff <= own_ff[SMDB_OWN_B2] && !own_ff[SMDB_OWN_B1];
            rate_q_ff <= rate_ff;
            sclk_ff <= wdata_ff[SMDB_CTRL_CPOL];
            left_ff <= len_ff;
            state_ff <= (len_ff == 7'h00) ? SMDB_STORE : SMDB_LOAD;
          end
        end
        SMDB_LOAD:
        begin
          sh_ff <= dir_q_ff ? 8'hFF : bif.rdata;
          edge_ff <= 4'h0;
          div_ff <= 14'h0000;
          if (!cpha_q_ff)
            dout_ff <= dir_q_ff ? 1'b1 : (lsbf_q_ff ? bif.rdata[0] : bif.rdata[7]);
          state_ff <= SMDB_SHIFT;
        end
        SMDB_SHIFT:
        begin
          div_ff <= half_done ? 14'h0000 : div_ff + 14'h0001;
          if (half_done)
          begin
            sclk_ff <= !sclk_ff;
            edge_ff <= edge_ff + 4'h1;
            if (samp_edge)
              sh_ff <= lsbf_q_ff ? {SERIAL_DATA_IN, sh_ff[7:1]} : {sh_ff[6:0], SERIAL_DATA_IN};
            else if (!(cpha_q_ff == 1'b0 && edge_ff == 4'h0))
              dout_ff <= dir_q_ff ? 1'b1 : nxt_bit;
            if (last_edge)
              state_ff <= SMDB_STORE;
          end
        end
        SMDB_STORE:
        begin
          if (left_ff > 7'h01)
          begin
            left_ff <= left_ff - 7'h01;
            state_ff <= SMDB_LOAD;
          end
          else
          begin
            left_ff <= 7'h00;
            state_ff <= SMDB_IDLE;
          end
        end
        default:
          state_ff <= SMDB_IDLE;
      endcase
    end
  end
  // zero count still raises done once
  //////////////////////////////////////////////////////////////////////////////
  // buffer pointer
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      ptr_ff <= 6'h00;
    else if (wr_lo && (wi == SMDB_IDX_CTRL) && wdata_ff[SMDB_CTRL_PCLR] && (state_ff == SMDB_IDLE))
      ptr_ff <= 6'h00;
    else if ((state_ff == SMDB_STORE) && (left_ff != 7'h00))
      ptr_ff <= ptr_ff + 6'h01;
  end
  //////////////////////////////////////////////////////////////////////////////
  // pins: 0 clock, 1 data out, 2 data in
  // function select
  always_comb
  begin
    if (ctrl_ff[SMDB_CTRL_PINSEL])
    begin
      PIN_OUT = {1'b0, dout_ff, sclk_ff};
      PIN_OE_N = 3'b100;
    end
    else
    begin
      PIN_OUT = GPIO_OUT;
      PIN_OE_N = GPIO_OE_N;
    end
  end
  assign GPIO_IN = PIN_IN;
  assign SERIAL_CLOCK_OUT = sclk_ff;
  assign SERIAL_DATA_OUT = dout_ff;
endmodule

/* smdb_engine_sva.sv */
/*
 checker of the serial master top: bus answers, pin routing, serial clock spacing.
 assumes it is bound into smdb_engine and shares its tick parameter.
*/
`timescale 1ns/1ps
module smdb_engine_sva
  import smdb_pkg::*;
#(
  parameter int TICK_CYC = SMDB_TICK_CYC
)
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [2:0] GPIO_OUT,
  input wire logic [2:0] GPIO_OE_N,
  input wire logic [2:0] GPIO_IN,
  input wire logic SERIAL_CLOCK_OUT,
  input wire logic SERIAL_DATA_OUT,
  input wire logic [2:0] PIN_OUT,
  input wire logic [2:0] PIN_OE_N,
  input wire logic [2:0] PIN_IN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] gap_ff; // cycles since the serial clock last moved
  // restart the count at every clock move, saturate when idle
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
      gap_ff <= 8'hFF;
    else if ($changed(SERIAL_CLOCK_OUT))
      gap_ff <= 8'h00;
    else if (gap_ff != 8'hFF)
      gap_ff <= gap_ff + 8'h01;
  ////////////////////////////////////////////////////////////////////////////////
  bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped early");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped early");
  read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  read_refuse_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while answer pending");
  write_refuse_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while answer pending");
  pin_route_a: assert property ((PIN_OUT != GPIO_OUT || PIN_OE_N != GPIO_OE_N) |->
    PIN_OE_N == 3'b100 && PIN_OUT[1:0] == {SERIAL_DATA_OUT, SERIAL_CLOCK_OUT}) else $error("pin routing wrong");
  gpio_in_a: assert property (GPIO_IN == PIN_IN)
    else $error("pin input not passed on");
  clock_gap_a: assert property ($changed(SERIAL_CLOCK_OUT) |-> gap_ff >= TICK_CYC - 1)
    else $error("serial half period too short");
endmodule
bind smdb_engine smdb_engine_sva #(.TICK_CYC(TICK_CYC)) chk (.*);

/* smdb_slave_model.sv */
/*
 serial slave model: takes bytes from the master, returns queued bytes.
 assumes mode and bit order are set by the bench before it is selected.
*/
`timescale 1ns/1ps
module smdb_slave_model
(
  input wire logic sck,
  input wire logic mosi,
  input wire logic cs_n,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsbf,
  output logic miso
);
  int tx_q[$]; // bytes to send back
  int rx_q[$]; // bytes taken in
  logic [7:0] rx_sh; // receive shifter
  logic [7:0] cur; // byte being sent
  int in_n;
  int out_n;
  // present the next bit, loading a new byte when one is spent
  task automatic shift_out();
    if (out_n == 8)
    begin
      cur = tx_q.size() ? 8'(tx_q.pop_front()) : 8'h00;
      out_n = 0;
    end
    miso = lsbf ? cur[out_n] : cur[7 - out_n];
    out_n++;
  endtask
  initial miso = 1'b0;
  // released line shows the inverse of its last level
  always @(posedge cs_n) miso = ~miso;
  always @(negedge cs_n)
  begin
    in_n = 0;
    out_n = 8;
    if (!cpha)
      shift_out();
  end
  always @(sck)
    if (!cs_n)
    begin
      if ((sck != cpol) ^ cpha)
      begin
        rx_sh = lsbf ? {mosi, rx_sh[7:1]} : {rx_sh[6:0], mosi};
        in_n++;
        if (in_n == 8)
        begin
          rx_q.push_back(rx_sh);
          in_n = 0;
        end
      end
      else
        shift_out();
    end
endmodule

/* smdb_engine_tb.sv */
/*
 bench of the serial master: register bus, buffer transfers in all modes, interrupt.
 assumes the checker binds itself and a slave model sits on the pins.
*/
`timescale 1ns/1ps
module smdb_engine_tb
  import smdb_pkg::*;
;
  localparam logic [31:0] A_CTRL = 32'(SMDB_IDX_CTRL) * 4;
  localparam logic [31:0] A_RATE = 32'(SMDB_IDX_RATE) * 4;
  localparam logic [31:0] A_LEN = 32'(SMDB_IDX_LEN) * 4;
  localparam logic [31:0] A_OWN = 32'(SMDB_IDX_OWN) * 4;
  localparam logic [31:0] A_STAT = 32'(SMDB_IDX_IRQ_STAT) * 4;
  localparam logic [31:0] A_MASK = 32'(SMDB_IDX_IRQ_MASK) * 4;
  localparam logic [31:0] A_B1 = 32'(SMDB_IDX_BUF1) * 4;
  localparam logic [31:0] A_B2 = 32'(SMDB_IDX_BUF2) * 4;
  localparam int LENS [6] = '{3, 2, 5, 4, 0, 64}; // bytes per transfer
  localparam int RATES [6] = '{0, 1, 0, 2, 1, 0}; // rate select per transfer
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, sck, sdo;
  logic [31:0] awaddr, wdata, araddr, rdata, rv;
  logic [1:0] bresp, rresp, rs;
  logic [2:0] gpo, gpoe_n, gpi, pin_out, pin_oe_n, pin_in;
  logic cs_n, cpol, cpha, lsbf, miso, d;
  logic [7:0] lfsr_ff, b;
  int error_cnt, checks_done, ptr, n;
  int exp_q[$]; // bytes expected at the far end, or in buffer two on receive
  ////////////////////////////////////////////////////////////////////////////////
  // wire levels: undriven pins 0 and 1 show a changing pattern, pin 2 shows the slave data
  assign pin_in[0] = pin_oe_n[0] ? lfsr_ff[0] : pin_out[0];
  assign pin_in[1] = pin_oe_n[1] ? lfsr_ff[1] : pin_out[1];
  assign pin_in[2] = pin_oe_n[2] ? miso : pin_out[2];
  smdb_engine #(.TICK_CYC(2)) dut (.CLK(clk), .RSTN(rstn),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .GPIO_OUT(gpo), .GPIO_OE_N(gpoe_n), .GPIO_IN(gpi), .SERIAL_CLOCK_OUT(sck),
    .SERIAL_DATA_OUT(sdo), .SERIAL_DATA_IN(pin_in[2]), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
    .PIN_IN(pin_in), .IRQ(irq));
  smdb_slave_model slv (.sck(pin_in[0]), .mosi(pin_in[1]), .cs_n(cs_n), .cpol(cpol), .cpha(cpha),
    .lsbf(lsbf), .miso(miso));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // random general-purpose drive every cycle
  always @(posedge clk)
  begin
    lfsr_ff <= nx(lfsr_ff);
    gpo <= lfsr_ff[2:0];
    gpoe_n <= lfsr_ff[5:3];
  end
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        rv = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, cpol, cpha, lsbf} = '0;
    {awaddr, wdata, araddr, gpo} = '0;
    gpoe_n = 3'h7;
    cs_n = 1'b1;
    lfsr_ff = 8'h3E;
    {error_cnt, checks_done, ptr} = '0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    foreach (LENS[k])
    begin
      rd(k == 0 ? A_CTRL : k == 1 ? A_RATE : k == 2 ? A_LEN : k == 3 ? A_OWN : k == 4 ? A_STAT : A_MASK);
      chk({rs, rv}, 34'h0);
    end
    rd(32'h3FC);
    chk({rs, rv}, {2'b10, 32'h0});
    wr(32'h3FC, 32'hFF);
    chk(rs, 2'b10);
    wr(A_CTRL, 0);
    @(posedge clk);
    #1 chk({pin_out, pin_oe_n}, {gpo, gpoe_n});
    for (int i = 0; i < 6; i++)
    begin
      n = LENS[i];
      d = (i == 1 || i == 3);
      {cpol, cpha, lsbf} = {i[1], i[0], (i == 1 || i == 2)};
      exp_q.delete();
      slv.rx_q.delete();
      slv.tx_q.delete();
      wr(A_OWN, 0);
      if (i == 0 || i == 4)
      begin
        wr(A_CTRL, 32'h81);
        ptr = 0;
      end
      for (int k = 0; k < n; k++)
      begin
        b = lfsr_ff;
        exp_q.push_back(b);
        if (d)
        begin
          slv.tx_q.push_back(b);
          @(posedge clk);
        end
        else wr(A_B1 + 4 * ((ptr + k) % 64), 32'(b));
      end
      wr(A_OWN, d ? 32'h04 : 32'h08);
      wr(A_LEN, n);
      wr(A_RATE, RATES[i]);
      wr(A_CTRL, 32'h80 | (cpol << 5) | (cpha << 4) | (d << 3) | (lsbf << 2));
      wr(A_MASK, i[0]);
      chk(sck, cpol);
      cs_n <= 1'b0;
      wr(A_CTRL, 32'hC0 | (cpol << 5) | (cpha << 4) | (d << 3) | (lsbf << 2));
      rd(A_CTRL);
      if (n > 0) chk(rv[6], 1'b1);
      for (int k = 0; k < 3000 && rv[6] !== 1'b0; k++) rd(A_CTRL);
      chk(rv[6], 1'b0);
      cs_n <= 1'b1;
      @(posedge clk);
      chk(sck, cpol);
      chk(irq, i[0]);
      rd(A_STAT);
      chk(rv[0], 1'b1);
      wr(A_STAT, 1);
      @(posedge clk);
      chk(irq, 1'b0);
      wr(A_OWN, 0);
      for (int k = 0; k < n; k++)
      begin
        if (d) rd(A_B2 + 4 * ((ptr + k) % 64));
        if (d) chk(rv[7:0], exp_q[k]);
        else chk(slv.rx_q[k], exp_q[k]);
      end
      if (!d) chk(slv.rx_q.size(), n);
      ptr = (ptr + n) % 64;
    end
    conclude();
  end
endmodule
